/* File: dv/atsl_logger_monitor.sv */
// Port checker for the alarm timestamp serial logger
`timescale 1ns/1ps
module atsl_logger_monitor #(
	parameter [16:0] BIT_CYC = 17'h1_4585       // Cycles per serial bit
) (
	input  wire        ref_clk_i,
	input  wire        sys_rst_i,
	input  wire        high_alarm_i,
	input  wire        cal_sw_i,
	input  wire        btn_low_i,
	input  wire        btn_high_i,
	input  wire        btn_cal_i,
	input  wire        btn_dead_i,
	input  wire        txd_o,
	input  wire        relay_o,
	input  wire [15:0] disp_o,
	input  wire        disp_act_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	// ------
	// Helper counters
	// ------
	reg        txd_q;  // Line level one cycle back
	reg [19:0] run;    // Cycles the line has held its level
	reg [19:0] quiet;  // Idle cycles seen in calibration position
	// Track level runs and quiet time on the line
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			txd_q <= 1'b1;
			run   <= 20'h0_0000;
			quiet <= 20'h0_0000;
		end else begin
			txd_q <= txd_o;
			run   <= (txd_o != txd_q) ? 20'h0_0001 : run + 20'h0_0001;
			quiet <= (cal_sw_i && txd_o) ? quiet + 20'h0_0001 : 20'h0_0000;
		end
	end
	// ------
	// Chords held long enough to pass the synchronisers
	// ------
	sequence s_mmdd; (btn_low_i && btn_high_i) [*5]; endsequence
	sequence s_year; (btn_low_i && btn_cal_i && !btn_high_i) [*5]; endsequence
	sequence s_hhmm; (btn_low_i && btn_dead_i && !btn_high_i && !btn_cal_i) [*5]; endsequence
	property p_relay_on; high_alarm_i [*4] |-> relay_o; endproperty
	property p_relay_off; !high_alarm_i [*4] |-> !relay_o; endproperty
	property p_disp_idle; !disp_act_o |-> disp_o == 16'h0000; endproperty
	property p_mmdd; s_mmdd |-> disp_act_o && disp_o >= 16'h0101 && disp_o <= 16'h1231 && disp_o[7:0] != 8'h00;
	endproperty
	property p_year; s_year |-> disp_act_o && disp_o[15:12] < 4'ha && disp_o[11:8] < 4'ha
		&& disp_o[7:4] < 4'ha && disp_o[3:0] < 4'ha; endproperty
	property p_hhmm; s_hhmm |-> disp_act_o && disp_o <= 16'h2359 && disp_o[7:4] < 4'h6 && disp_o[3:0] < 4'ha;
	endproperty
	// A low stretch always ends on a whole number of bits, never past start plus eight data bits
	property p_bit_time; (txd_o && !txd_q) |-> (run % BIT_CYC == 0) && run <= 9 * BIT_CYC; endproperty
	property p_cal_quiet; (cal_sw_i && quiet > 3 * BIT_CYC) |-> txd_o; endproperty
	property p_reset_idle; $fell(sys_rst_i) |-> txd_o && !relay_o && !disp_act_o; endproperty
	a_relay_on: assert property (p_relay_on) else $error("relay not driven in high alarm");
	a_relay_off: assert property (p_relay_off) else $error("relay driven without alarm");
	a_disp_idle: assert property (p_disp_idle) else $error("display value without chord");
	a_mmdd: assert property (p_mmdd) else $error("month day value out of range");
	a_year: assert property (p_year) else $error("year value not four digits");
	a_hhmm: assert property (p_hhmm) else $error("hour minute value out of range");
	a_bit_time: assert property (p_bit_time) else $error("serial bit time wrong");
	a_cal_quiet: assert property (p_cal_quiet) else $error("serial output in calibration");
	a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
endmodule // atsl_logger_monitor

bind atsl_logger atsl_logger_monitor #(.BIT_CYC(BIT_CYC)) u_mon (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
	.high_alarm_i(high_alarm_i), .cal_sw_i(cal_sw_i), .btn_low_i(btn_low_i), .btn_high_i(btn_high_i),
	.btn_cal_i(btn_cal_i), .btn_dead_i(btn_dead_i), .txd_o(txd_o), .relay_o(relay_o), .disp_o(disp_o),
	.disp_act_o(disp_act_o));

/* File: dv/atsl_logger_tb.sv */
// Self-checking bench for the alarm timestamp serial logger
`timescale 1ns/1ps
module atsl_logger_tb;
	localparam int SEC_CYC = 1100;   // Shortened second
	localparam int BIT_CYC = 3;      // Shortened bit cell
	reg         ref_clk_i;
	reg         sys_rst_i;
	reg         high_alarm_i;
	reg         det_fail_i;
	reg         cal_sw_i;
	reg  [3:0]  chord;               // Dead, cal, high, low buttons
	reg         up;
	reg         dn;
	reg  [19:0] reading;
	reg  [19:0] rd;
	wire        txd;
	wire        relay;
	wire [15:0] disp;
	wire        disp_act;
	wire [7:0]  rx_data;
	wire        rx_stb;
	wire        rx_ferr;
	int         mismatches;
	int         checks;
	int         cyc;
	int         t_set;               // Cycle when the clock read 23:59:00
	logic [7:0] rxq[$];
	logic [3:0]  ch_t[5] = '{4'h3, 4'h3, 4'h3, 4'h5, 4'h9};
	bit          up_t[5] = '{0, 1, 1, 0, 0};
	logic [15:0] ex_t[5] = '{16'h1231, 16'h0101, 16'h0102, 16'h9999, 16'h2359};
	atsl_logger #(.SEC_CYC(SEC_CYC), .BIT_CYC(BIT_CYC)) u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.clk_en_i(1'b1), .high_alarm_i(high_alarm_i), .det_fail_i(det_fail_i), .cal_sw_i(cal_sw_i),
		.btn_low_i(chord[0]), .btn_high_i(chord[1]), .btn_cal_i(chord[2]), .btn_dead_i(chord[3]),
		.btn_up_i(up), .btn_down_i(dn), .reading_i(reading), .txd_o(txd), .relay_o(relay),
		.disp_o(disp), .disp_act_o(disp_act));
	atsl_printer #(.BIT_CYC(BIT_CYC)) u_prn (.clk_i(ref_clk_i), .rxd_i(txd), .data_o(rx_data),
		.stb_o(rx_stb), .ferr_o(rx_ferr));
	// ------
	// Clock, byte collector, watchdog
	// ------
	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (rx_stb === 1'b1)
			rxq.push_back(rx_data);
	end
	initial begin
		repeat (86 * SEC_CYC) @(posedge ref_clk_i);
		mismatches++;
		report_and_stop();
	end
	// ------
	// Comparison and expectation helpers
	// ------
	task automatic tally(input bit ok, input string msg);
		checks++;
		if (!ok) begin
			mismatches++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	task automatic cmp_disp(input logic [15:0] got, input logic [15:0] exp);
		tally(got === exp, "display value");
	endtask
	task automatic cmp_cnt(input int got, input int exp);
		tally(got == exp, "byte count");
	endtask
	task automatic cmp_rec(input logic [271:0] got, input logic [271:0] exp);
		tally(got === exp, "record bytes");
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		tally(got === exp, "signal level");
	endtask
	function automatic [7:0] asc(input [3:0] v);
		asc = {4'h3, v};
	endfunction
	function automatic [7:0] bcd(input int v);
		bcd = {4'(v / 10), 4'(v % 10)};
	endfunction
	function automatic [19:0] rnd_bcd();
		for (int i = 0; i < 5; i++)
			rnd_bcd = {rnd_bcd[15:0], 4'($urandom % 10)};
	endfunction
	// Month is always January and year 99 in these runs
	function automatic [271:0] mk_rec(input [19:0] r, input [7:0] da, hh, mi, ss, input bit fl);
		mk_rec = {asc(r[19:16]), asc(r[15:12]), asc(r[11:8]), asc(r[7:4]), 8'h2e, asc(r[3:0]), 24'h20_2020,
			16'h3031, 8'h2f, asc(da[7:4]), asc(da[3:0]), 8'h2f, 16'h3939, 8'h20, asc(hh[7:4]), asc(hh[3:0]),
			8'h3a, asc(mi[7:4]), asc(mi[3:0]), 8'h3a, asc(ss[7:4]), asc(ss[3:0]), 8'h20,
			fl ? 40'h20_4641_494c : 40'h41_4c41_524d, 16'h0d0a};
	endfunction
	// Hold a chord, step once, then read the display
	task automatic edit(input [3:0] ch, input bit u, input [15:0] exp);
		chord <= ch;
		repeat (6) @(posedge ref_clk_i);
		up <= u;
		dn <= !u;
		t_set = cyc;
		repeat (4) @(posedge ref_clk_i);
		up <= 1'b0;
		dn <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		cmp_disp(disp, exp);
		cmp_bit(disp_act, 1'b1);
		chord <= 4'h0;
		repeat (6) @(posedge ref_clk_i);
	endtask
	// Await one record; seconds may differ by one from the bench's estimate
	task automatic run_rec(input [19:0] r, input bit fl, input int lim);
		logic [271:0] got;
		int s;
		int ss;
		int gs;
		int k;
		k = 0;
		while (rxq.size() < 34 && k < lim) begin
			@(posedge ref_clk_i);
			k++;
		end
		s = (cyc - 34 * (10 * BIT_CYC + 2) - t_set) / SEC_CYC;
		for (int i = 0; i < 34; i++)
			got = {got[263:0], (rxq.size() > 0) ? rxq.pop_front() : 8'h00};
		ss = s % 60;
		gs = got[75:72] * 10 + got[67:64];
		if ((gs - ss) * (gs - ss) <= 1)
			ss = gs;
		cmp_rec(got, mk_rec(r, s >= 60 ? 8'h03 : 8'h02, s >= 60 ? 8'h00 : 8'h23, s >= 60 ? 8'h00 : 8'h59,
			bcd(ss), fl));
	endtask
	task automatic report_and_stop;
		if (mismatches == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ------
	// Main sequence
	// ------
	initial begin
		{sys_rst_i, high_alarm_i, det_fail_i, cal_sw_i, up, dn} = 6'h20;
		{chord, reading, cyc, mismatches, checks, t_set} = '0;
		void'($urandom(32'hb5af8315));
		repeat (16) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		for (int i = 0; i < 5; i++)
			edit(ch_t[i], up_t[i], ex_t[i]);
		repeat (35 * SEC_CYC) @(posedge ref_clk_i);
		rd = rnd_bcd();
		reading <= rd;
		high_alarm_i <= 1'b1;
		run_rec(rd, 1'b0, 3 * SEC_CYC);
		cmp_bit(relay, 1'b1);
		rd = rnd_bcd();
		reading <= rd;
		run_rec(rd, 1'b0, 32 * SEC_CYC);
		high_alarm_i <= 1'b0;
		repeat (20) @(posedge ref_clk_i);
		cmp_bit(relay, 1'b0);
		rd = rnd_bcd();
		reading <= rd;
		{high_alarm_i, det_fail_i} <= 2'h3;
		run_rec(rd, 1'b1, 3 * SEC_CYC);
		{high_alarm_i, det_fail_i, cal_sw_i} <= 3'h1;
		repeat (20) @(posedge ref_clk_i);
		det_fail_i <= 1'b1;
		repeat (3 * SEC_CYC) @(posedge ref_clk_i);
		cmp_cnt(rxq.size(), 0);
		det_fail_i <= 1'b0;
		repeat (20) @(posedge ref_clk_i);
		cal_sw_i <= 1'b0;
		repeat (2 * SEC_CYC) @(posedge ref_clk_i);
		cmp_cnt(rxq.size(), 0);
		cmp_bit(rx_ferr, 1'b0);
		report_and_stop();
	end
endmodule // atsl_logger_tb

/* File: dv/atsl_printer.sv */
// Receive-only serial printer model
`timescale 1ns/1ps
module atsl_printer #(
	parameter int BIT_CYC = 3       // Cycles per serial bit
) (
	input  wire       clk_i,
	input  wire       rxd_i,
	output reg  [7:0] data_o,
	output reg        stb_o,
	output reg        ferr_o
);
	// ------
	// Frame receiver
	// ------
	// Sample each bit mid-cell, LSB first; a bad start or stop sticks in ferr_o
	initial begin
		data_o = 8'h00;
		stb_o  = 1'b0;
		ferr_o = 1'b0;
		forever begin
			@(negedge rxd_i);
			repeat (BIT_CYC / 2 + 1) @(posedge clk_i);
			if (rxd_i !== 1'b0)
				ferr_o = 1'b1;
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge clk_i);
				data_o <= {rxd_i, data_o[7:1]};
			end
			repeat (BIT_CYC) @(posedge clk_i);
			if (rxd_i !== 1'b1)
				ferr_o = 1'b1;
			stb_o <= 1'b1;
			@(posedge clk_i);
			stb_o <= 1'b0;
		end
	end
endmodule // atsl_printer

/* File: inc/atsl_defines.vh */
// Constants shared by the alarm timestamp serial logger
`ifndef ATSL_DEFINES_VH
`define ATSL_DEFINES_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ATSL_CLK_HZ      32'h0beb_c200             // Clock rate in Hz
`define ATSL_BAUD        16'h0960                  // Line rate in bit/s
`define ATSL_SEC_S       4'h1                      // Calendar step in seconds
`define ATSL_REPEAT_S    5'h1e                     // Repeat interval, 30 seconds
`define ATSL_BIT_CYC     17'h1_4585                // Clock rate over line rate, sized for the bit counter
`define ATSL_SEC_CYC     28'hbeb_c200              // Clock rate times one second, sized for the prescaler

// ----------------------------------------------------------------
// Record and FIFO geometry
// ----------------------------------------------------------------
`define ATSL_REC_LAST    6'h21                     // Index of last byte (34 bytes)
`define ATSL_FIFO_W      8
`define ATSL_FIFO_D      32
`define ATSL_FIFO_AW     5

// ----------------------------------------------------------------
// Calendar limits and reset values
// ----------------------------------------------------------------
`define ATSL_SEC_MAX     6'h3b                     // 59
`define ATSL_MIN_MAX     6'h3b                     // 59
`define ATSL_HOUR_MAX    5'h17                     // 23
`define ATSL_MON_MAX     4'hc                      // 12
`define ATSL_YEAR_MAX    14'h270f                  // 9999
`define ATSL_RST_MON     4'h1
`define ATSL_RST_DAY     5'h01
`define ATSL_RST_YEAR    14'h0000

// ----------------------------------------------------------------
// Characters
// ----------------------------------------------------------------
`define ATSL_CH_SPACE    8'h20
`define ATSL_CH_DOT      8'h2e
`define ATSL_CH_SLASH    8'h2f
`define ATSL_CH_COLON    8'h3a
`define ATSL_CH_ZERO     8'h30
`define ATSL_CH_CR       8'h0d
`define ATSL_CH_LF       8'h0a
`define ATSL_CH_A        8'h41
`define ATSL_CH_F        8'h46
`define ATSL_CH_I        8'h49
`define ATSL_CH_L        8'h4c
`define ATSL_CH_M        8'h4d
`define ATSL_CH_R        8'h52

`endif

/* File: rtl/atsl_logger.v */
// Alarm timestamp serial logger: calendar, record framer, FIFO and serial transmitter
`timescale 1ns/1ps
`include "atsl_defines.vh"

// ----------------------------------------------------------------
// Byte FIFO between framer and transmitter
// ----------------------------------------------------------------
module atsl_fifo #(
	parameter W  = 8,
	parameter D  = 32,
	parameter AW = 5
) (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire         en_i,
	input  wire         in_valid_i,
	output wire         in_ready_o,
	input  wire [W-1:0] in_data_i,
	output wire         out_valid_o,
	input  wire         out_ready_i,
	output wire [W-1:0] out_data_o
);
	reg  [W-1:0] mem [0:D-1];   // Storage
	reg  [AW:0]  wr_ptr;        // Write pointer with wrap bit
	reg  [AW:0]  rd_ptr;        // Read pointer with wrap bit
	wire         full;
	wire         empty;

	assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign empty       = (wr_ptr == rd_ptr);
	assign in_ready_o  = ~full;
	assign out_valid_o = ~empty;
	assign out_data_o  = mem[rd_ptr[AW-1:0]];

	// Pointer and storage update
	always @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
		end else if (en_i) begin
			if (in_valid_i && !full) begin
				mem[wr_ptr[AW-1:0]] <= in_data_i;
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (out_ready_i && !empty)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule // atsl_fifo

module atsl_logger #(
	parameter [27:0] SEC_CYC = `ATSL_SEC_CYC,      // Cycles per second
	parameter [16:0] BIT_CYC = `ATSL_BIT_CYC       // Cycles per serial bit
) (
	input  wire        ref_clk_i,
	input  wire        sys_rst_i,
	input  wire        clk_en_i,
	input  wire        high_alarm_i,
	input  wire        det_fail_i,
	input  wire        cal_sw_i,
	input  wire        btn_low_i,
	input  wire        btn_high_i,
	input  wire        btn_cal_i,
	input  wire        btn_dead_i,
	input  wire        btn_up_i,
	input  wire        btn_down_i,
	input  wire [19:0] reading_i,
	output reg         txd_o,
	output reg         relay_o,
	output reg  [15:0] disp_o,
	output reg         disp_act_o
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam [1:0] ST_IDLE = 2'b01;               // Framer waiting
	localparam [1:0] ST_SEND = 2'b10;               // Framer pushing bytes

	reg  [8:0]  sync1;                              // First synchroniser stage
	reg  [8:0]  sync2;                              // Second synchroniser stage
	reg         up_d;                               // Up button history
	reg         down_d;                             // Down button history
	reg         cond_d;                             // Condition history
	reg  [27:0] sec_cnt;                            // Second prescaler
	reg  [5:0]  sec;                                // Calendar seconds
	reg  [5:0]  min;                                // Calendar minutes
	reg  [4:0]  hour;                               // Calendar hours
	reg  [4:0]  day;                                // Calendar day
	reg  [3:0]  mon;                                // Calendar month
	reg  [13:0] year;                               // Calendar year
	reg  [4:0]  rep_cnt;                            // Seconds since last record
	reg         pending;                            // Record requested
	reg  [1:0]  state;                              // Framer state
	reg  [5:0]  idx;                                // Byte index in record
	reg  [19:0] s_rd;                               // Captured reading
	reg  [7:0]  s_mo, s_dy, s_yr, s_hr, s_mi, s_se; // Captured BCD time
	reg         s_fail;                             // Captured condition kind
	reg  [9:0]  tx_shift;                           // Frame shift register
	reg  [3:0]  tx_bits;                            // Bits already sent
	reg  [16:0] tx_cnt;                             // Bit-time counter
	reg         tx_busy;                            // Transmitter active
	reg         tx_take;                            // FIFO pop strobe
	wire        alarm_s, fail_s, cal_s, low_s, high_s, calb_s, dead_s, up_s, down_s;
	wire        sec_tick, cond, cond_rise, rep_due, req, start;
	wire        ch_md, ch_yr, ch_hm, step_up, step_dn;
	wire        f_ready, f_valid;
	wire [7:0]  f_data;
	wire [4:0]  dim_cur;

	assign {alarm_s, fail_s, cal_s, low_s, high_s, calb_s, dead_s, up_s, down_s} = sync2;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Days in a month, leap years every fourth year
	function [4:0] dim;
		input [3:0]  m;
		input [13:0] y;
		begin
			if (m == 4'h2)
				dim = (y[1:0] == 2'b00) ? 5'h1d : 5'h1c;
			else if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hb)
				dim = 5'h1e;
			else
				dim = 5'h1f;
		end
	endfunction

	// Two BCD digits from a binary value below 100
	function [7:0] bcd2;
		input [13:0] v;
		reg   [13:0] q;                                 // Tens
		reg   [13:0] r;                                 // Units
		begin
			q    = v / 14'h000a;
			r    = v % 14'h000a;
			bcd2 = {q[3:0], r[3:0]};
		end
	endfunction

	// ASCII digit from one BCD nibble
	function [7:0] asc;
		input [3:0] d;
		begin
			asc = `ATSL_CH_ZERO | {4'h0, d};
		end
	endfunction

	// Record byte at a given index from captured values
	function [7:0] rec_byte;
		input [5:0] i;
		begin
			case (i)
				6'h00: rec_byte = asc(s_rd[19:16]);
				6'h01: rec_byte = asc(s_rd[15:12]);
				6'h02: rec_byte = asc(s_rd[11:8]);
				6'h03: rec_byte = asc(s_rd[7:4]);
				6'h04: rec_byte = `ATSL_CH_DOT;
				6'h05: rec_byte = asc(s_rd[3:0]);
				6'h09: rec_byte = asc(s_mo[7:4]);
				6'h0a: rec_byte = asc(s_mo[3:0]);
				6'h0b: rec_byte = `ATSL_CH_SLASH;
				6'h0c: rec_byte = asc(s_dy[7:4]);
				6'h0d: rec_byte = asc(s_dy[3:0]);
				6'h0e: rec_byte = `ATSL_CH_SLASH;
				6'h0f: rec_byte = asc(s_yr[7:4]);
				6'h10: rec_byte = asc(s_yr[3:0]);
				6'h12: rec_byte = asc(s_hr[7:4]);
				6'h13: rec_byte = asc(s_hr[3:0]);
				6'h14: rec_byte = `ATSL_CH_COLON;
				6'h15: rec_byte = asc(s_mi[7:4]);
				6'h16: rec_byte = asc(s_mi[3:0]);
				6'h17: rec_byte = `ATSL_CH_COLON;
				6'h18: rec_byte = asc(s_se[7:4]);
				6'h19: rec_byte = asc(s_se[3:0]);
				6'h1b: rec_byte = s_fail ? `ATSL_CH_SPACE : `ATSL_CH_A;
				6'h1c: rec_byte = s_fail ? `ATSL_CH_F : `ATSL_CH_L;
				6'h1d: rec_byte = s_fail ? `ATSL_CH_A : `ATSL_CH_A;
				6'h1e: rec_byte = s_fail ? `ATSL_CH_I : `ATSL_CH_R;
				6'h1f: rec_byte = s_fail ? `ATSL_CH_L : `ATSL_CH_M;
				6'h20: rec_byte = `ATSL_CH_CR;
				6'h21: rec_byte = `ATSL_CH_LF;
				default: rec_byte = `ATSL_CH_SPACE;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// Input synchronisers and edge detection
	// ----------------------------------------------------------------
	// Two flops on every alarm, switch and button input (reading_i is not synchronised); edges are taken from the second
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			sync1  <= 9'h000;
			sync2  <= 9'h000;
			up_d   <= 1'b0;
			down_d <= 1'b0;
			cond_d <= 1'b0;
		end else if (clk_en_i) begin
			sync1  <= {high_alarm_i, det_fail_i, cal_sw_i, btn_low_i, btn_high_i,
				btn_cal_i, btn_dead_i, btn_up_i, btn_down_i};
			sync2  <= sync1;
			up_d   <= up_s;
			down_d <= down_s;
			cond_d <= cond;
		end
	end

	assign ch_md     = low_s & high_s;
	assign ch_yr     = low_s & calb_s & ~high_s;
	assign ch_hm     = low_s & dead_s & ~high_s & ~calb_s;
	assign step_up   = up_s & ~up_d;
	assign step_dn   = down_s & ~down_d & ~step_up;
	assign cond      = alarm_s | fail_s;
	assign cond_rise = cond & ~cond_d;
	assign sec_tick  = (sec_cnt == SEC_CYC - 28'h000_0001);
	assign dim_cur   = dim(mon, year);

	// ----------------------------------------------------------------
	// Calendar clock and field setting
	// ----------------------------------------------------------------
	// Chord edits take priority over the once-a-second advance
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			sec_cnt <= 28'h000_0000;
			sec     <= 6'h00;
			min     <= 6'h00;
			hour    <= 5'h00;
			day     <= `ATSL_RST_DAY;
			mon     <= `ATSL_RST_MON;
			year    <= `ATSL_RST_YEAR;
		end else if (clk_en_i) begin
			sec_cnt <= sec_tick ? 28'h000_0000 : sec_cnt + 28'h000_0001;
			if (ch_md && step_up) begin
				if (day == dim_cur) begin
					day <= 5'h01;
					mon <= (mon == `ATSL_MON_MAX) ? 4'h1 : mon + 4'h1;
				end else
					day <= day + 5'h01;
			end else if (ch_md && step_dn) begin
				if (day == 5'h01) begin
					mon <= (mon == 4'h1) ? `ATSL_MON_MAX : mon - 4'h1;
					day <= dim((mon == 4'h1) ? `ATSL_MON_MAX : mon - 4'h1, year);
				end else
					day <= day - 5'h01;
			end else if (ch_yr && step_up) begin
				year <= (year == `ATSL_YEAR_MAX) ? 14'h0000 : year + 14'h0001;
			end else if (ch_yr && step_dn) begin
				year <= (year == 14'h0000) ? `ATSL_YEAR_MAX : year - 14'h0001;
			end else if (ch_hm && step_up) begin
				sec <= 6'h00;
				if (min == `ATSL_MIN_MAX) begin
					min  <= 6'h00;
					hour <= (hour == `ATSL_HOUR_MAX) ? 5'h00 : hour + 5'h01;
				end else
					min <= min + 6'h01;
			end else if (ch_hm && step_dn) begin
				sec <= 6'h00;
				if (min == 6'h00) begin
					min  <= `ATSL_MIN_MAX;
					hour <= (hour == 5'h00) ? `ATSL_HOUR_MAX : hour - 5'h01;
				end else
					min <= min - 6'h01;
			end else if (sec_tick) begin
				sec <= (sec == `ATSL_SEC_MAX) ? 6'h00 : sec + 6'h01;
				if (sec == `ATSL_SEC_MAX) begin
					min <= (min == `ATSL_MIN_MAX) ? 6'h00 : min + 6'h01;
					if (min == `ATSL_MIN_MAX) begin
						hour <= (hour == `ATSL_HOUR_MAX) ? 5'h00 : hour + 5'h01;
						if (hour == `ATSL_HOUR_MAX) begin
							day <= (day == dim_cur) ? 5'h01 : day + 5'h01;
							if (day == dim_cur) begin
								mon <= (mon == `ATSL_MON_MAX) ? 4'h1 : mon + 4'h1;
								if (mon == `ATSL_MON_MAX)
									year <= (year == `ATSL_YEAR_MAX) ? 14'h0000 : year + 14'h0001;
							end
						end
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Display and relay
	// ----------------------------------------------------------------
	// Display shows the chorded field only while the chord is held
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			disp_o     <= 16'h0000;
			disp_act_o <= 1'b0;
			relay_o    <= 1'b0;
		end else if (clk_en_i) begin
			relay_o    <= alarm_s;
			disp_act_o <= ch_md | ch_yr | ch_hm;
			if (ch_md)
				disp_o <= {bcd2({10'h000, mon}), bcd2({9'h000, day})};
			else if (ch_yr)
				disp_o <= {bcd2(year / 14'h0064), bcd2(year % 14'h0064)};
			else if (ch_hm)
				disp_o <= {bcd2({9'h000, hour}), bcd2({8'h00, min})};
			else
				disp_o <= 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// Record scheduling
	// ----------------------------------------------------------------
	assign rep_due = cond & sec_tick & (rep_cnt == `ATSL_REPEAT_S - 5'h01);
	assign req     = (cond_rise | rep_due) & ~cal_s;
	assign start   = (state == ST_IDLE) & pending & ~cal_s;

	// Seconds counter restarts at each onset and each repeat
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rep_cnt <= 5'h00;
			pending <= 1'b0;
		end else if (clk_en_i) begin
			if (!cond || cond_rise || rep_due)
				rep_cnt <= 5'h00;
			else if (sec_tick)
				rep_cnt <= rep_cnt + 5'h01;
			// A new request wins over the clear by start
			pending <= req | (pending & ~start & ~cal_s & cond);
		end
	end

	// ----------------------------------------------------------------
	// Record framer
	// ----------------------------------------------------------------
	// Captures time and reading, then pushes 34 bytes into the FIFO
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state  <= ST_IDLE;
			idx    <= 6'h00;
			s_rd   <= 20'h0_0000;
			{s_mo, s_dy, s_yr, s_hr, s_mi, s_se} <= 48'h0000_0000_0000;
			s_fail <= 1'b0;
		end else if (clk_en_i) begin
			case (state)
				ST_IDLE: begin
					idx <= 6'h00;
					if (start) begin
						s_rd   <= reading_i;
						s_mo   <= bcd2({10'h000, mon});
						s_dy   <= bcd2({9'h000, day});
						s_yr   <= bcd2(year % 14'h0064);
						s_hr   <= bcd2({9'h000, hour});
						s_mi   <= bcd2({8'h00, min});
						s_se   <= bcd2({8'h00, sec});
						s_fail <= fail_s;
						state  <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (f_ready) begin
						idx <= idx + 6'h01;
						if (idx == `ATSL_REC_LAST)
							state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	atsl_fifo #(
		.W  (`ATSL_FIFO_W),
		.D  (`ATSL_FIFO_D),
		.AW (`ATSL_FIFO_AW)
	) u_fifo (
		.clk_i       (ref_clk_i),
		.rst_i       (sys_rst_i),
		.en_i        (clk_en_i),
		.in_valid_i  (state == ST_SEND),
		.in_ready_o  (f_ready),
		.in_data_i   (rec_byte(idx)),
		.out_valid_o (f_valid),
		.out_ready_i (tx_take),
		.out_data_o  (f_data)
	);

	// ----------------------------------------------------------------
	// Serial transmitter
	// ----------------------------------------------------------------
	// Start bit, eight data bits LSB first, one stop bit, idle high
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			tx_shift <= 10'h3ff;
			tx_bits  <= 4'h0;
			tx_cnt   <= 17'h0_0000;
			tx_busy  <= 1'b0;
			tx_take  <= 1'b0;
			txd_o    <= 1'b1;
		end else if (clk_en_i) begin
			tx_take <= 1'b0;
			txd_o   <= tx_busy ? tx_shift[0] : 1'b1;
			if (!tx_busy) begin
				if (f_valid && !tx_take) begin
					tx_shift <= {1'b1, f_data, 1'b0};
					tx_bits  <= 4'h0;
					tx_cnt   <= 17'h0_0000;
					tx_busy  <= 1'b1;
					tx_take  <= 1'b1;
				end
			end else if (tx_cnt == BIT_CYC - 17'h0_0001) begin
				tx_cnt <= 17'h0_0000;
				if (tx_bits == 4'h9)
					tx_busy <= 1'b0;
				else begin
					tx_shift <= {1'b1, tx_shift[9:1]};
					tx_bits  <= tx_bits + 4'h1;
				end
			end else
				tx_cnt <= tx_cnt + 17'h0_0001;
		end
	end
endmodule // atsl_logger
